// file: inc/sched_pkg.sv
// Shared constants, types and helpers of the prefetch and bus scheduler
// Behaviour
// [RL1] Operand access wins the bus over a waiting prefetch.
// [RL2] Long operand uses two bus cycles, most significant word first.
// [RL3] Byte or word operand uses exactly one bus cycle.
// [RL4] Request during a running cycle is queued, started when it completes.
// [RL5] Fetch starts at sequencer address, then refills each invalidated stage.
// [RL6] Prefetch launches once no queued operand access remains.
// [RL7] Prefetch only with pipeline room and no change of flow ahead.
// [RL8] Pipeline flags imminent change of flow; prefetches are withheld.
// [RL9] Change of flow empties the pipeline and refills from new address.
// [RL10] Sequencer starts fetching after flow change and drives stage validation.
// [RL11] One buffered write lets the sequencer continue at once.
// [RL12] Sequencer stalls while the buffered write is still unperformed; the code holds back only further writes, reads are still queued.
// [RL13] Two decode stages fronted by an input buffer stage.
// [RL14] Every stage keeps an abnormal bus termination flag.
// [RL15] Bus work proceeds concurrently with sequencer internal work.
// [RL16] Partner completes each access in two clocks, no wait states.
// [RL17] Fixed priority gives repeatable access order for a given sequence.
// [RL18] Each instruction prefetches to replace its own words.
// [RL19] Prefetch may start in first clock of indexed address calculation.
// [RL20] Prefetch may start two clocks before instruction end if bus idle.
// [RL21] Overlap is the smaller of previous tail and next head.
// [RL22] Reset empties stages and write buffer; no fetch before start address.
`default_nettype none
package sched_pkg;
    localparam int          BUS_W    = 16;
    localparam int          ADDR_W   = 32;
    localparam int          OPD_W    = 32;
    localparam int          QDEPTH   = 4;
    localparam int          OCC_W    = 3;
    localparam int          CNT_W    = 4;
    localparam logic [1:0]  SZ_BYTE  = 2'h0;
    localparam logic [1:0]  SZ_WORD  = 2'h1;
    localparam logic [1:0]  SZ_LONG  = 2'h2;
    localparam logic [31:0] WORD_STEP = 32'h0000_0002;
    localparam logic [2:0]  OCC_RST  = 3'h0;
    localparam logic [3:0]  OVL_RST  = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_OPER  = 2'h1,
        ST_OPLO  = 2'h3,
        ST_FETCH = 2'h2
    } bus_st_t;

    typedef struct packed {
        logic              write;
        logic [1:0]        size;
        logic [ADDR_W-1:0] addr;
        logic [OPD_W-1:0]  wdata;
    } op_req_t;

    typedef struct packed {
        logic             err;
        logic [BUS_W-1:0] word;
    } fill_word_t;

    typedef struct packed {
        logic             valid;
        logic             err;
        logic [BUS_W-1:0] word;
    } stage_t;

    localparam int REQ_W  = $bits(op_req_t);
    localparam int FILL_W = $bits(fill_word_t);

    function automatic logic [ADDR_W-1:0] next_word(input logic [ADDR_W-1:0] a);
        return a + WORD_STEP;
    endfunction

    function automatic logic [CNT_W-1:0] min_cnt(input logic [CNT_W-1:0] x,
                                                 input logic [CNT_W-1:0] y);
        return (x < y) ? x : y;
    endfunction
endpackage
`default_nettype wire

// file: inc/stream_if.sv
// Valid/ready word channel between the scheduler's own modules
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: rtl/req_fifo.sv
// Request queue in flip-flops with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module req_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic mclk_i,   // System clock
    input  wire logic arst_n_i, // Async reset, active low
    stream_if.snk     in_s,     // Filling side
    stream_if.src     out_s     // Draining side
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [PW:0]             cnt;
    } fifo_state_t;

    fifo_state_t r_reg;
    fifo_state_t r_next;
    logic        push;
    logic        pop;

    assign in_s.ready  = (r_reg.cnt < (PW+1)'(DEPTH));
    assign out_s.valid = (r_reg.cnt != '0);
    assign out_s.data  = r_reg.mem[r_reg.rp];

    always_comb begin
        r_next = r_reg;
        push   = in_s.valid & in_s.ready;
        pop    = out_s.valid & out_s.ready;
        if (push) begin
            r_next.mem[r_reg.wp] = in_s.data;
            r_next.wp            = (r_reg.wp == PW'(DEPTH - 1)) ? '0 : r_reg.wp + 1'b1;
        end
        if (pop) begin
            r_next.rp = (r_reg.rp == PW'(DEPTH - 1)) ? '0 : r_reg.rp + 1'b1;
        end
        r_next.cnt = r_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule
`default_nettype wire

// file: rtl/instr_pipe.sv
// Three-stage instruction word pipeline: input buffer, decode, execute
`timescale 1ns/1ns
`default_nettype none
module instr_pipe (
    input  wire logic         mclk_i,        // System clock
    input  wire logic         arst_n_i,      // Async reset, active low
    stream_if.snk             fill_s,        // Prefetched words
    input  wire logic         flush_i,       // Change of flow
    input  wire logic         ext_use_i,     // Decode word used
    input  wire logic         instr_start_i, // Full advance
    output logic              a_valid_o,     // Buffer stage holds a word
    output logic [15:0]       b_word_o,      // Decode stage word
    output logic              b_valid_o,     // Decode stage valid
    output logic              b_err_o,       // Decode stage fault flag
    output logic [15:0]       c_word_o,      // Execute stage word
    output logic              c_valid_o,     // Execute stage valid
    output logic              c_err_o        // Execute stage fault flag
);
    typedef struct packed {
        sched_pkg::stage_t a;
        sched_pkg::stage_t b;
        sched_pkg::stage_t c;
    } pipe_state_t;

    pipe_state_t           r_reg;
    pipe_state_t           r_next;
    sched_pkg::fill_word_t fw;

    assign fill_s.ready = ~r_reg.a.valid;
    assign a_valid_o    = r_reg.a.valid;
    assign b_word_o     = r_reg.b.word;
    assign b_valid_o    = r_reg.b.valid;
    assign b_err_o      = r_reg.b.err;
    assign c_word_o     = r_reg.c.word;
    assign c_valid_o    = r_reg.c.valid;
    assign c_err_o      = r_reg.c.err;

    always_comb begin
        r_next = r_reg;
        fw     = sched_pkg::fill_word_t'(fill_s.data);
        if (flush_i) begin
            r_next = '0;                                  // [RL9]
        end else begin
            if (instr_start_i) begin
                r_next.c       = r_reg.b;                 // [RL13]
                r_next.b.valid = 1'b0;
            end else if (ext_use_i) begin
                r_next.b.valid = 1'b0;
            end
            // Words fall through to the next empty stage
            if (!r_next.c.valid && r_next.b.valid) begin
                r_next.c       = r_next.b;
                r_next.b.valid = 1'b0;
            end
            if (!r_next.b.valid && r_next.a.valid) begin
                r_next.b       = r_next.a;
                r_next.a.valid = 1'b0;
            end
            if (fill_s.valid && !r_reg.a.valid) begin
                r_next.a = '{valid: 1'b1, err: fw.err, word: fw.word}; // [RL14]
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r_reg <= '0;                                  // [RL22]
        end else begin
            r_reg <= r_next;
        end
    end
endmodule
`default_nettype wire

// file: rtl/prefetch_bus_scheduler.sv
// Bus controller: operand queue, write-pending buffer, prefetch and arbitration
`timescale 1ns/1ns
`default_nettype none
module prefetch_bus_scheduler (
    input  wire logic        mclk_i,          // System clock, 10 MHz
    input  wire logic        arst_n_i,        // Async reset, active low
    input  wire logic        seq_req_valid_i, // Operand request
    input  wire logic        seq_req_write_i, // 1 write, 0 read
    input  wire logic [1:0]  seq_req_size_i,  // Byte, word or long
    input  wire logic [31:0] seq_req_addr_i,  // Operand address
    input  wire logic [31:0] seq_req_wdata_i, // Write data
    output logic             seq_rd_ready_o,  // Read may be queued
    output logic             seq_wr_ready_o,  // Write may be queued
    output logic [31:0]      seq_rdata_o,     // Read result
    output logic             seq_rvalid_o,    // Read result pulse
    output logic             seq_rerr_o,      // Read ended abnormally
    input  wire logic        flow_start_i,    // Change of flow pulse
    input  wire logic [31:0] flow_addr_i,     // New instruction address
    input  wire logic        ext_use_i,       // Extension word consumed
    input  wire logic        instr_start_i,   // New instruction begins
    input  wire logic        cof_in_b_i,      // Decode sees a flow change
    input  wire logic        idx_ea_first_i,  // First clock of indexed EA
    input  wire logic        end_two_i,       // Two clocks before instr end
    input  wire logic [3:0]  tail_i,          // Tail of ending instruction
    input  wire logic [3:0]  head_i,          // Head of next instruction
    output logic [15:0]      irb_word_o,      // Decode stage word
    output logic             irb_valid_o,     // Decode stage valid
    output logic             irb_err_o,       // Decode stage fault flag
    output logic [15:0]      irc_word_o,      // Execute stage word
    output logic             irc_valid_o,     // Execute stage valid
    output logic             irc_err_o,       // Execute stage fault flag
    output logic             cof_inhibit_o,   // Prefetch withheld
    output logic             wp_full_o,       // Write pending
    output logic [3:0]       overlap_o,       // Instruction overlap clocks
    output logic             bus_req_o,       // Cycle request, held to ack
    output logic [31:0]      bus_addr_o,      // Cycle address
    output logic             bus_write_o,     // Write cycle
    output logic             bus_byte_o,      // Byte-sized cycle
    output logic             bus_fetch_o,     // Instruction fetch cycle
    output logic [15:0]      bus_wdata_o,     // Write data word
    input  wire logic        bus_ack_i,       // Cycle complete
    input  wire logic [15:0] bus_rdata_i,     // Read data word
    input  wire logic        bus_berr_i       // Abnormal termination
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        sched_pkg::bus_st_t st;
        logic               req;
        logic [31:0]        addr;
        logic               write;
        logic               byte_sz;
        logic               fetch;
        logic [15:0]        wdata;
        logic [1:0]         cur_size;
        logic [15:0]        lo_wdata;
        logic [15:0]        rd_hi;
        logic               rerr_acc;
        logic [31:0]        rdata;
        logic               rvalid;
        logic               rerr;
        logic               fetch_en;
        logic [31:0]        fetch_addr;
        logic               drop;
        logic               early;
        logic               hold_v;
        logic               hold_err;
        logic [15:0]        hold_word;
        logic               wp_full;
        logic [2:0]         occ;
        logic               rd_ready;
        logic               wr_ready;
        logic               cof_inh;
        logic [3:0]         overlap;
    } core_state_t;

    core_state_t        r_reg;
    core_state_t        r_next;
    sched_pkg::op_req_t head;
    logic               push;
    logic               pop;
    logic               done;
    logic               room;
    logic [1:0]         free_cnt;
    logic               a_valid;

    ////////////////////////////////////////////////////////////////////////
    // Operand queue and instruction pipeline
    stream_if #(.W(sched_pkg::REQ_W))  q_in ();
    stream_if #(.W(sched_pkg::REQ_W))  q_out ();
    stream_if #(.W(sched_pkg::FILL_W)) fill ();

    assign q_in.valid = push;
    assign q_in.data  = {seq_req_write_i, seq_req_size_i, seq_req_addr_i, seq_req_wdata_i};
    assign q_out.ready = pop;
    assign head        = sched_pkg::op_req_t'(q_out.data);
    assign fill.valid  = r_reg.hold_v;
    assign fill.data   = {r_reg.hold_err, r_reg.hold_word};

    req_fifo #(
        .W     (sched_pkg::REQ_W),
        .DEPTH (sched_pkg::QDEPTH)
    ) u_queue (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .in_s     (q_in),
        .out_s    (q_out)
    );

    instr_pipe u_pipe (
        .mclk_i        (mclk_i),
        .arst_n_i      (arst_n_i),
        .fill_s        (fill),
        .flush_i       (flow_start_i),
        .ext_use_i     (ext_use_i),
        .instr_start_i (instr_start_i),
        .a_valid_o     (a_valid),
        .b_word_o      (irb_word_o),
        .b_valid_o     (irb_valid_o),
        .b_err_o       (irb_err_o),
        .c_word_o      (irc_word_o),
        .c_valid_o     (irc_valid_o),
        .c_err_o       (irc_err_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    assign seq_rd_ready_o = r_reg.rd_ready;
    assign seq_wr_ready_o = r_reg.wr_ready;
    assign seq_rdata_o    = r_reg.rdata;
    assign seq_rvalid_o   = r_reg.rvalid;
    assign seq_rerr_o     = r_reg.rerr;
    assign cof_inhibit_o  = r_reg.cof_inh;
    assign wp_full_o      = r_reg.wp_full;
    assign overlap_o      = r_reg.overlap;
    assign bus_req_o      = r_reg.req;
    assign bus_addr_o     = r_reg.addr;
    assign bus_write_o    = r_reg.write;
    assign bus_byte_o     = r_reg.byte_sz;
    assign bus_fetch_o    = r_reg.fetch;
    assign bus_wdata_o    = r_reg.wdata;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        r_next   = r_reg;
        r_next.rvalid = 1'b0;
        r_next.rerr   = 1'b0;
        // Writes wait until the buffered write is performed
        push = seq_req_valid_i & q_in.ready
             & (seq_req_write_i ? r_reg.wr_ready : r_reg.rd_ready);  // [RL12]
        pop  = 1'b0;
        done = bus_ack_i & r_reg.req;

        if (r_reg.hold_v && fill.ready) begin
            r_next.hold_v = 1'b0;                                    // [RL13]
        end

        if (done) begin
            case (r_reg.st)
                sched_pkg::ST_OPER, sched_pkg::ST_OPLO: begin
                    if (r_reg.st == sched_pkg::ST_OPER
                        && r_reg.cur_size == sched_pkg::SZ_LONG) begin
                        r_next.st       = sched_pkg::ST_OPLO;        // [RL2]
                        r_next.addr     = sched_pkg::next_word(r_reg.addr);
                        r_next.wdata    = r_reg.lo_wdata;
                        r_next.rd_hi    = bus_rdata_i;
                        r_next.rerr_acc = bus_berr_i;
                    end else begin
                        r_next.st  = sched_pkg::ST_IDLE;             // [RL3]
                        r_next.req = 1'b0;
                        if (r_reg.write) begin
                            r_next.wp_full = 1'b0;
                        end else begin
                            r_next.rvalid = 1'b1;
                            r_next.rdata  = {r_reg.rd_hi, bus_rdata_i};  // [RL2]
                            r_next.rerr   = r_reg.rerr_acc | bus_berr_i;
                        end
                    end
                end
                sched_pkg::ST_FETCH: begin
                    r_next.st    = sched_pkg::ST_IDLE;
                    r_next.req   = 1'b0;
                    r_next.fetch = 1'b0;
                    r_next.drop  = 1'b0;
                    if (!(r_reg.drop || flow_start_i)) begin
                        r_next.hold_v     = 1'b1;
                        r_next.hold_err   = bus_berr_i;              // [RL14]
                        r_next.hold_word  = bus_rdata_i;
                        r_next.fetch_addr = sched_pkg::next_word(r_reg.fetch_addr);
                    end
                end
                default: begin
                    r_next.st  = sched_pkg::ST_IDLE;
                    r_next.req = 1'b0;
                end
            endcase
        end

        if (flow_start_i) begin
            r_next.fetch_en   = 1'b1;                                // [RL10]
            r_next.fetch_addr = flow_addr_i;                         // [RL5]
            r_next.hold_v     = 1'b0;                                // [RL9]
            if (r_reg.st == sched_pkg::ST_FETCH && !done) begin
                r_next.drop = 1'b1;
            end
        end

        // Early windows stay open until a fetch launches, a new instruction starts or the flow changes
        if (instr_start_i || flow_start_i) begin
            r_next.early = 1'b0;
        end
        if (idx_ea_first_i || end_two_i) begin
            r_next.early = 1'b1;                                     // [RL19] [RL20]
        end

        // Room: free stages against words already on the way
        free_cnt = 2'(!a_valid) + 2'(!irb_valid_o) + 2'(!irc_valid_o);
        room     = ({1'b0, free_cnt} + 3'(r_reg.early)) > 3'(r_reg.hold_v); // [RL18]

        // Fixed priority keeps the access order repeatable
        if (r_next.st == sched_pkg::ST_IDLE) begin                   // [RL4] [RL17]
            if (q_out.valid) begin
                pop               = 1'b1;                            // [RL1] [RL6]
                r_next.st         = sched_pkg::ST_OPER;
                r_next.req        = 1'b1;
                r_next.fetch      = 1'b0;
                r_next.write      = head.write;
                r_next.cur_size   = head.size;
                r_next.addr       = head.addr;
                r_next.byte_sz    = (head.size == sched_pkg::SZ_BYTE);
                r_next.wdata      = (head.size == sched_pkg::SZ_LONG)
                                  ? head.wdata[31:16] : head.wdata[15:0];
                r_next.lo_wdata   = head.wdata[15:0];
                r_next.rd_hi      = '0;
                r_next.rerr_acc   = 1'b0;
            end else if (r_next.fetch_en && !r_next.hold_v && room
                         && !(r_reg.cof_inh && !flow_start_i)) begin // [RL7] [RL8]
                r_next.st       = sched_pkg::ST_FETCH;               // [RL5]
                r_next.req      = 1'b1;
                r_next.fetch    = 1'b1;
                r_next.write    = 1'b0;
                r_next.byte_sz  = 1'b0;
                r_next.cur_size = sched_pkg::SZ_WORD;
                r_next.addr     = r_next.fetch_addr;
                r_next.early    = 1'b0;
            end
        end

        // Write buffer: set wins over a completing write
        if (push && seq_req_write_i) begin
            r_next.wp_full = 1'b1;                                   // [RL11]
        end

        // Ready outputs come from a mirrored count
        r_next.occ      = r_reg.occ + 3'(push) - 3'(pop);
        r_next.rd_ready = (r_next.occ < 3'(sched_pkg::QDEPTH));     // [RL15]
        r_next.wr_ready = r_next.rd_ready && !r_next.wp_full;       // [RL12]

        r_next.cof_inh  = cof_in_b_i && irb_valid_o && !flow_start_i; // [RL8]

        if (instr_start_i) begin
            r_next.overlap = sched_pkg::min_cnt(tail_i, head_i);     // [RL21]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r_reg          <= '0;                                   // [RL22]
            r_reg.st       <= sched_pkg::ST_IDLE;
            r_reg.cur_size <= sched_pkg::SZ_WORD;
            r_reg.occ      <= sched_pkg::OCC_RST;
            r_reg.overlap  <= sched_pkg::OVL_RST;
            r_reg.rd_ready <= 1'b1;
            r_reg.wr_ready <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule
`default_nettype wire

// file: verif/prefetch_bus_scheduler_chk.sv
// Port checker for the prefetch and bus scheduler
`timescale 1ns/1ns
`default_nettype none
module prefetch_bus_scheduler_chk (
    input wire logic        mclk_i,       // Clock
    input wire logic        arst_n_i,     // Reset
    input wire logic        bus_req_o,    // Cycle request
    input wire logic        bus_ack_i,    // Cycle done
    input wire logic [31:0] bus_addr_o,   // Cycle address
    input wire logic        bus_fetch_o,  // Fetch cycle
    input wire logic        bus_write_o,  // Write cycle
    input wire logic        flow_start_i, // Flow change
    input wire logic        irb_valid_o,  // Decode valid
    input wire logic        irc_valid_o,  // Execute valid
    input wire logic        wp_full_o,    // Write pending
    input wire logic        seq_rvalid_o  // Read result
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    property p_hold; bus_req_o && !bus_ack_i |=> bus_req_o && $stable(bus_addr_o); endproperty
    a_hold: assert property (p_hold) else $error("bus cycle dropped early");
    property p_kind; bus_req_o && !bus_ack_i |=> $stable(bus_fetch_o) && $stable(bus_write_o); endproperty
    a_kind: assert property (p_kind) else $error("bus cycle kind changed");
    property p_wpclr; $fell(wp_full_o) |-> $past(bus_ack_i && bus_req_o && bus_write_o); endproperty
    a_wpclr: assert property (p_wpclr) else $error("write buffer freed early");
    property p_wpdo; $rose(wp_full_o) |-> ##[0:60] bus_req_o && bus_write_o; endproperty
    a_wpdo: assert property (p_wpdo) else $error("buffered write not run");
    property p_flush; flow_start_i |=> (!irb_valid_o && !irc_valid_o) [*3]; endproperty
    a_flush: assert property (p_flush) else $error("pipeline not emptied");
    property p_refetch; flow_start_i |-> ##[1:60] bus_req_o && bus_fetch_o; endproperty
    a_refetch: assert property (p_refetch) else $error("no fetch after flow");
    property p_rdata; seq_rvalid_o |-> $past(bus_ack_i && bus_req_o && !bus_fetch_o); endproperty
    a_rdata: assert property (p_rdata) else $error("read result without cycle");
    property p_prio; $rose(bus_req_o && bus_fetch_o) |-> !wp_full_o || !$past(wp_full_o); endproperty
    a_prio: assert property (p_prio) else $error("fetch ahead of write");
endmodule
bind prefetch_bus_scheduler prefetch_bus_scheduler_chk u_prefetch_bus_scheduler_chk (.*);
`default_nettype wire

// file: verif/mem_model.sv
// On-chip memory model: two-clock access, no wait states
`timescale 1ns/1ns
`default_nettype none
module mem_model (
    input  wire logic        mclk_i,   // Clock
    input  wire logic        arst_n_i, // Reset
    input  wire logic        req_i,    // Cycle request
    input  wire logic [31:0] addr_i,   // Cycle address
    output logic             ack_o,    // Cycle done
    output logic             berr_o,   // Abnormal end
    output logic [15:0]      rdata_o   // Read word
);
    logic go;
    assign go = req_i && !ack_o;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {ack_o, berr_o, rdata_o} <= '0;
        end else begin
            ack_o <= go;
            berr_o <= go && addr_i[15:8] == 8'hEE;
            rdata_o <= go ? addr_i[15:0] ^ 16'h5A5A : ~rdata_o;
        end
    end
endmodule
`default_nettype wire

// file: verif/prefetch_bus_scheduler_tb.sv
// Self-checking bench for the prefetch and bus scheduler
`timescale 1ns/1ns
`default_nettype none
module prefetch_bus_scheduler_tb;
    logic mclk_i = 0, arst_n_i = 0, seq_req_valid_i = 0, seq_req_write_i = 0, flow_start_i = 0;
    logic ext_use_i = 0, instr_start_i = 0, cof_in_b_i = 0, idx_ea_first_i = 0, end_two_i = 0;
    logic seq_rd_ready_o, seq_wr_ready_o, seq_rvalid_o, seq_rerr_o, irb_valid_o;
    logic irb_err_o, irc_valid_o, irc_err_o, cof_inhibit_o, wp_full_o, bus_req_o, bus_write_o;
    logic bus_byte_o, bus_fetch_o, bus_ack_i, bus_berr_i;
    logic [1:0] seq_req_size_i = 0;
    logic [3:0] tail_i = 0, head_i = 0, overlap_o;
    logic [15:0] irb_word_o, irc_word_o, bus_wdata_o, bus_rdata_i;
    logic [31:0] seq_req_addr_i = 0, seq_req_wdata_i = 0, flow_addr_i = 0, seq_rdata_o, bus_addr_o;
    logic [31:0] opa[$];
    int errors = 0, tests_run = 0, cyc = 0;
    prefetch_bus_scheduler u_prefetch_bus_scheduler (.*);
    mem_model u_mem_model (.mclk_i, .arst_n_i, .req_i(bus_req_o), .addr_i(bus_addr_o),
        .ack_o(bus_ack_i), .berr_o(bus_berr_i), .rdata_o(bus_rdata_i));
    function automatic logic [15:0] mw(input logic [31:0] a);
        return a[15:0] ^ 16'h5A5A;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wt(ref logic s, input logic v);
        repeat (80) begin
            @(posedge mclk_i);
            if (s === v) break;
        end
    endtask
    always #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        if (bus_req_o && bus_ack_i && !bus_fetch_o) opa.push_back(bus_addr_o);
        cyc++;
        if (cyc == 30000) begin
            errors++;
            finish_test();
        end
    end
    task automatic flow(input logic [31:0] a);
        logic [3:0] t, h;
        {t, h} = 8'($urandom);
        @(posedge mclk_i);
        {flow_start_i, flow_addr_i} <= {1'b1, a};
        @(posedge mclk_i);
        flow_start_i <= 0;
        wt(irb_valid_o, 1);
        chk("irb_word", irb_word_o, mw(a));
        chk("irb_err", irb_err_o, a[15:8] == 8'hEE);
        {instr_start_i, tail_i, head_i} <= {1'b1, t, h};
        @(posedge mclk_i);
        instr_start_i <= 0;
        @(posedge mclk_i);
        chk("overlap", overlap_o, t < h ? t : h);
        chk("irc_word", irc_word_o, mw(a));
        chk("irc_err", irc_err_o, a[15:8] == 8'hEE);
        wt(irb_valid_o, 1);
        chk("irb_next", irb_word_o, mw(a + 2));
    endtask
    task automatic op(input logic w, input logic [1:0] s, input logic [31:0] a);
        logic [31:0] d;
        d = $urandom;
        opa.delete();
        @(posedge mclk_i);
        {seq_req_valid_i, seq_req_write_i, seq_req_size_i, seq_req_addr_i, seq_req_wdata_i} <=
            {1'b1, w, s, a, d};
        do @(posedge mclk_i); while ((w ? seq_wr_ready_o : seq_rd_ready_o) !== 1'b1);
        seq_req_valid_i <= 0;
        if (w) begin
            @(posedge mclk_i);
            chk("wp_full", wp_full_o, 1);
            chk("wr_ready", seq_wr_ready_o, 0);
            wt(wp_full_o, 0);
        end else begin
            wt(seq_rvalid_o, 1);
            chk("rdata", seq_rdata_o, s == 2 ? {mw(a), mw(a + 2)} : {16'h0, mw(a)});
        end
        chk("cycles", opa.size(), s == 2 ? 2 : 1);
        chk("addr_first", opa[0], a);
    endtask
    initial begin
        void'($urandom(32'h0EED1ECC));
        repeat (16) @(posedge mclk_i);
        arst_n_i <= 1;
        repeat (4) @(posedge mclk_i);
        chk("idle_req", {bus_req_o, wp_full_o, irb_valid_o, irc_valid_o}, 0);
        flow($urandom & 32'hFFFF_7FFE);
        flow(32'h0000_EE00);
        for (int i = 0; i < 24; i++) op(1'($urandom), 2'(i % 3), $urandom & 32'hFFFF_7FFE);
        repeat (300) begin
            @(posedge mclk_i);
            {cof_in_b_i, ext_use_i, idx_ea_first_i, end_two_i, seq_req_valid_i} <= 5'($urandom);
            {seq_req_write_i, seq_req_addr_i} <= {1'($urandom), $urandom & 32'hFFFF_7FFE};
            {seq_req_size_i, instr_start_i} <= {2'($urandom % 3), 1'($urandom % 8 == 0)};
        end
        {seq_req_valid_i, ext_use_i, instr_start_i, idx_ea_first_i, end_two_i} <= 0;
        repeat (100) @(posedge mclk_i);
        finish_test();
    end
endmodule
`default_nettype wire
